/* File: rtl/adcsp_top.sv */
// Converter control and serial port: conversion sequencing, result and config
// state, and the SPI slave on the host's serial clock.
// Assumes analog_code and temp_code come from the modulator on core_clk.
`timescale 1ns/1ps
`default_nettype none
module adcsp_top #(
  parameter int TIMEOUT_CYC = adcsp_pkg::TIMEOUT_CYCLES, // Idle-clock timeout, core cycles
  parameter int CONV_SHIFT = 0                            // Shortens conversions by 2^n
) (
  input wire logic core_clk,                         // Core clock, 10 MHz
  input wire logic rst,                              // Synchronous reset, high
  input wire logic sclk,                             // Serial clock from host
  input wire logic cs_n,                             // Chip select, low active
  input wire logic serial_in,                        // Serial data from host
  output logic serial_out_ready,                     // Shared data / ready pin level
  output logic serial_out_ready_oe,                  // Pin actively driven
  output logic out_weak_hold_on,                     // Weak pull-up engaged
  input wire logic signed [16:0] analog_code,        // Raw channel code, may overrange
  input wire logic [adcsp_pkg::TEMP_BITS-1:0] temp_code, // Sensor code
  output logic [2:0] gain_range_select,              // Range to front end
  output logic temp_sense_select,                    // Sensor selected
  output logic [12:0] fsr_mv,                        // Full-scale range, mV
  output logic [27:0] lsb_pv,                        // Step size, pV
  output logic [15:0] config_word,                   // Current configuration
  output logic [15:0] conv_result,                   // Conversion register
  output logic new_data,                             // Unread result pending
  output logic powered_up                            // Converting
);
  import adcsp_pkg::*;

  adcsp_core_t core_reg;
  adcsp_core_t core_next;
  adcsp_tx_t tx_reg;
  adcsp_tx_t tx_next;
  adcsp_rx_t rx_reg;
  adcsp_rx_t rx_next;
  logic link_rst;

  function automatic logic [16:0] conv_len(input logic [2:0] rate);
    logic [16:0] t;
    t = CONV_TICKS[rate] >> CONV_SHIFT;
    if (t == 17'h00000) begin
      t = 17'h00001;
    end
    return t;
  endfunction

  function automatic logic [15:0] saturate(input logic signed [16:0] raw);
    logic [15:0] v;
    v = raw[15:0];
    if (raw[16] != raw[15]) begin
      v = raw[16] ? SAT_NEG : SAT_POS;
    end
    return v;
  endfunction

  // Link side clears on deselect or on a clock timeout
  assign link_rst = cs_n | core_reg.link_reset;

  // Core domain
  always_comb begin
    logic tick;
    logic cs_fall;
    logic cs_high;
    logic wr_event;
    logic done;
    logic [15:0] wr;
    logic lead;
    tick = 1'b0;
    cs_fall = 1'b0;
    cs_high = 1'b0;
    wr_event = 1'b0;
    done = 1'b0;
    wr = 16'h0000;
    lead = 1'b0;
    core_next = core_reg;

    core_next.cs_sync = {core_reg.cs_sync[1:0], cs_n};
    core_next.sclk_sync = {core_reg.sclk_sync[0], sclk};
    core_next.wr_sync = {core_reg.wr_sync[1:0], rx_reg.rx_valid};
    cs_high = core_reg.cs_sync[1];
    cs_fall = core_reg.cs_sync[2] & ~core_reg.cs_sync[1];
    wr_event = core_reg.wr_sync[1] & ~core_reg.wr_sync[2];

    // Oscillator tick divided from the core clock
    if (core_reg.osc_cnt == 4'(OSC_DIV - 1)) begin
      core_next.osc_cnt = 4'h0;
      tick = 1'b1;
    end else begin
      core_next.osc_cnt = core_reg.osc_cnt + 4'h1;
    end

    // Config write from a completed frame
    if (wr_event) begin
      wr = rx_reg.rx_word;
      if (core_reg.state == ADCSP_CONVERT) begin
        wr[CFG_SS_BIT] = 1'b0;
      end
      core_next.cfg = wr;
    end

    case (core_reg.state)
      ADCSP_IDLE: begin
        core_next.powered = 1'b0;
        if (!core_next.cfg[CFG_MODE_BIT]) begin
          core_next.state = ADCSP_CONVERT;
          core_next.powered = 1'b1;
          core_next.ticks_left = conv_len(core_next.cfg[CFG_RATE_LSB +: 3]);
        end else if (core_next.cfg[CFG_SS_BIT]) begin
          core_next.cfg[CFG_SS_BIT] = 1'b0;
          core_next.state = ADCSP_CONVERT;
          core_next.powered = 1'b1;
          core_next.ticks_left = conv_len(core_next.cfg[CFG_RATE_LSB +: 3]);
        end
      end
      ADCSP_CONVERT: begin
        if (tick) begin
          if (core_reg.ticks_left <= 17'h00001) begin
            done = 1'b1;
          end else begin
            core_next.ticks_left = core_reg.ticks_left - 17'h00001;
          end
        end
        if (done) begin
          if (core_reg.cfg[CFG_TEMP_BIT]) begin
            core_next.result = {temp_code, 2'b00};
          end else begin
            core_next.result = saturate(analog_code);
          end
          if (core_next.cfg[CFG_MODE_BIT]) begin
            core_next.state = ADCSP_IDLE;
            core_next.powered = 1'b0;
          end else begin
            core_next.ticks_left = conv_len(core_next.cfg[CFG_RATE_LSB +: 3]);
          end
        end
      end
      default: begin
        core_next.state = ADCSP_IDLE;
        core_next.powered = 1'b0;
      end
    endcase

    // Completion beats a frame start in the same cycle
    if (done) begin
      core_next.new_data = 1'b1;
    end else if (cs_fall) begin
      core_next.new_data = 1'b0;
    end

    // Unread result withdrawn shortly before the next one lands
    lead = (core_reg.state == ADCSP_CONVERT) && !core_reg.cfg[CFG_MODE_BIT]
        && (core_reg.ticks_left <= READY_LEAD_TICKS);

    // Snapshot for the frame; held while chip select stays low
    if (cs_fall) begin
      core_next.tx_word = core_reg.result;
    end
    // Ready level frozen once selected, so the flag clear cannot flip it
    if (cs_high || cs_fall) begin
      core_next.ready_pin = ~(core_reg.new_data & ~lead);
    end
    core_next.out_oe = ~cs_high;
    core_next.weak_hold = cs_high & core_reg.cfg[CFG_HOLD_BIT];

    // Serial clock idle-low watchdog, fires once per idle stretch
    core_next.link_reset = 1'b0;
    if (cs_high || core_reg.sclk_sync[1]) begin
      core_next.idle_cnt = 20'h00000;
    end else if (core_reg.idle_cnt != 20'(TIMEOUT_CYC)) begin
      core_next.idle_cnt = core_reg.idle_cnt + 20'h00001;
      if (core_reg.idle_cnt == 20'(TIMEOUT_CYC - 1)) begin
        core_next.link_reset = 1'b1;
      end
    end

    core_next.fsr_mv = FSR_MV[core_reg.cfg[CFG_GAIN_LSB +: 3]];
    core_next.lsb_pv = LSB_PV[core_reg.cfg[CFG_GAIN_LSB +: 3]];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      core_reg <= '0;
      core_reg.state <= ADCSP_IDLE;
      core_reg.cfg <= CFG_RESET;
      core_reg.result <= RESULT_RESET;
      core_reg.ready_pin <= 1'b1;
      core_reg.cs_sync <= 3'h7;
      core_reg.weak_hold <= 1'b1;
      core_reg.fsr_mv <= FSR_MV[CFG_RESET[CFG_GAIN_LSB +: 3]];
      core_reg.lsb_pv <= LSB_PV[CFG_RESET[CFG_GAIN_LSB +: 3]];
    end else begin
      core_reg <= core_next;
    end
  end

  // Link domain, rising edges: shift the snapshot out MSB first
  always_comb begin
    tx_next = tx_reg;
    tx_next.started = 1'b1;
    if (tx_reg.bit_cnt < FRAME_BITS) begin
      tx_next.out_bit = core_reg.tx_word[4'(5'd15 - tx_reg.bit_cnt)];
      tx_next.bit_cnt = tx_reg.bit_cnt + 5'd1;
    end else begin
      tx_next.out_bit = 1'b0;
    end
  end

  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      tx_reg <= '0;
    end else begin
      tx_reg <= tx_next;
    end
  end

  // Link domain, falling edges: collect the config word
  always_comb begin
    rx_next = rx_reg;
    if (rx_reg.rx_cnt < FRAME_BITS) begin
      rx_next.rx_shift = {rx_reg.rx_shift[14:0], serial_in};
      rx_next.rx_cnt = rx_reg.rx_cnt + 5'd1;
      if (rx_reg.rx_cnt == FRAME_BITS - 5'd1) begin
        rx_next.rx_word = {rx_reg.rx_shift[14:0], serial_in};
        rx_next.rx_valid = 1'b1;
      end
    end
  end

  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      rx_reg <= '0;
    end else begin
      rx_reg <= rx_next;
    end
  end

  // Data once the first rising edge has come, ready level before that
  assign serial_out_ready = tx_reg.started ? tx_reg.out_bit : core_reg.ready_pin;
  assign serial_out_ready_oe = core_reg.out_oe;
  assign out_weak_hold_on = core_reg.weak_hold;
  assign gain_range_select = core_reg.cfg[CFG_GAIN_LSB +: 3];
  assign temp_sense_select = core_reg.cfg[CFG_TEMP_BIT];
  assign fsr_mv = core_reg.fsr_mv;
  assign lsb_pv = core_reg.lsb_pv;
  assign config_word = core_reg.cfg;
  assign conv_result = core_reg.result;
  assign new_data = core_reg.new_data;
  assign powered_up = core_reg.powered;
endmodule
`default_nettype wire

/* File: rtl/adcsp_pkg.sv */
// Constants, tables and types for the converter control and serial port block.
// Assumes a 10 MHz core clock and a host SPI master that drives the serial clock.
// Behaviour
// - Three-bit gain field picks one of six full-scale ranges, 6.144 V to 0.256 V.
// - One code step equals the chosen full-scale span divided by 2^16.
// - Temperature select bit set to one measures the internal sensor.
// - Temperature result is 14 bits, left-justified in 16, high byte first.
// - Temperature step is 0.03125 C, negatives in two's complement.
// - Reset loads config defaults and starts powered down, logic still alive.
// - Mode one is single-shot and powered down; mode zero converts continuously.
// - Trigger bit in single-shot powers up, self-clears, converts once, powers down.
// - Trigger written while a conversion runs is ignored.
// - Continuous mode stores each result and restarts at once.
// - Continuous mode ends on a mode write of one or on reset.
// - Chip select high resets the serial port, ignores clocks, floats output.
// - Chip select low drives output: low if unread result, else high.
// - Result copied at transfer start and held until the transfer ends.
// - Serial clock low for 28 ms resets the serial port.
// - Input sampled on falling serial clock edges; input pin never driven.
// - Output bits change on rising serial clock edges.
// - Output/ready pin goes low when a fresh result is ready.
// - Continuous, unread: ready returns high 8 us before the next ready.
// - Weak hold on output while deselected unless its enable bit is zero.
// - Conversion timing comes from a 1 MHz oscillator tick.
// - Results are 16-bit two's complement, saturated at 7fff and 8000.
package adcsp_pkg;
  localparam int CORE_HZ = 10_000_000;
  localparam int OSC_HZ = 1_000_000;
  localparam int OSC_DIV = CORE_HZ / OSC_HZ;
  localparam int WORD_BITS = 16;
  localparam int TEMP_BITS = 14;
  localparam int TIMEOUT_MS = 28;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CORE_HZ / 1000);
  localparam int READY_LEAD_US = 8;
  localparam logic [16:0] READY_LEAD_TICKS = 17'(READY_LEAD_US * (OSC_HZ / 1_000_000));
  localparam logic [15:0] CFG_RESET = 16'h058b;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] SAT_POS = 16'h7fff;
  localparam logic [15:0] SAT_NEG = 16'h8000;
  localparam int CFG_SS_BIT = 15;
  localparam int CFG_GAIN_LSB = 9;
  localparam int CFG_MODE_BIT = 8;
  localparam int CFG_RATE_LSB = 5;
  localparam int CFG_TEMP_BIT = 4;
  localparam int CFG_HOLD_BIT = 3;
  localparam logic [4:0] FRAME_BITS = 5'd16;
  // Oscillator ticks per conversion, indexed by the rate field
  localparam logic [16:0] CONV_TICKS [8] = '{
    17'h1e848, 17'h0f424, 17'h07a12, 17'h03d09,
    17'h01e84, 17'h00fa0, 17'h00839, 17'h0048a};
  localparam logic [12:0] FSR_MV [8] = '{
    13'h1800, 13'h1000, 13'h0800, 13'h0400, 13'h0200, 13'h0100, 13'h0100, 13'h0100};
  // Step size in picovolts: twice the range over 2^16
  localparam logic [27:0] LSB_PV [8] = '{
    28'hb2d05e0, 28'h7735940, 28'h3b9aca0, 28'h1dcd650,
    28'h0ee6b28, 28'h0773594, 28'h0773594, 28'h0773594};

  typedef enum logic {ADCSP_IDLE, ADCSP_CONVERT} adcsp_state_t;

  typedef struct packed {
    adcsp_state_t state;
    logic powered;
    logic [15:0] cfg;
    logic [15:0] result;
    logic new_data;
    logic ready_pin;
    logic [15:0] tx_word;
    logic [3:0] osc_cnt;
    logic [16:0] ticks_left;
    logic [2:0] cs_sync;
    logic [1:0] sclk_sync;
    logic [2:0] wr_sync;
    logic [19:0] idle_cnt;
    logic link_reset;
    logic out_oe;
    logic weak_hold;
    logic [12:0] fsr_mv;
    logic [27:0] lsb_pv;
  } adcsp_core_t;

  typedef struct packed {
    logic started;
    logic [4:0] bit_cnt;
    logic out_bit;
  } adcsp_tx_t;

  typedef struct packed {
    logic [4:0] rx_cnt;
    logic [15:0] rx_shift;
    logic [15:0] rx_word;
    logic rx_valid;
  } adcsp_rx_t;
endpackage

/* File: testbench/adcsp_asserts.sv */
// Checker bound to adcsp_top: pin, conversion and result timing.
// Assumes synced chip select lags the pin by up to four core cycles.
`timescale 1ns/1ps
`default_nettype none
module adcsp_asserts (
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic cs_n, // Select
  input wire logic serial_out_ready, // Pin
  input wire logic serial_out_ready_oe, // Drive
  input wire logic signed [16:0] analog_code, // Code
  input wire logic [adcsp_pkg::TEMP_BITS-1:0] temp_code, // Sensor
  input wire logic temp_sense_select, // Sensor on
  input wire logic [12:0] fsr_mv, // Range
  input wire logic [15:0] config_word, // Config
  input wire logic [15:0] conv_result, // Result
  input wire logic new_data, // Unread
  input wire logic powered_up // Busy
);
  wire logic shot = config_word[8];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  function automatic logic [12:0] fsr_of(input logic [2:0] g);
    return (g == 3'h0) ? 13'h1800 : (g > 3'h4) ? 13'h0100 : 13'(13'h1000 >> (g - 3'h1));
  endfunction
  function automatic logic [15:0] sat(input logic signed [16:0] c);
    return (c > 17'sh07fff) ? 16'h7fff : (c < 17'sh18000) ? 16'h8000 : c[15:0];
  endfunction
  a_oe_on_select: assert property (
    $fell(cs_n) |-> ##[1:5] serial_out_ready_oe) else $error("pin not driven");
  a_pin_released: assert property (
    cs_n [*5] |-> !serial_out_ready_oe) else $error("pin driven when deselected");
  a_range_map: assert property (
    $stable(config_word) |-> fsr_mv == fsr_of(config_word[11:9])) else $error("bad range");
  a_shot_clears: assert property (
    $rose(powered_up) |-> !config_word[15]) else $error("trigger kept");
  a_shot_ends: assert property (
    $rose(new_data) && shot && $past(shot) |-> ##[0:1] !powered_up) else $error("still on");
  a_cont_restart: assert property (
    $changed(conv_result) && !shot && !$past(shot) |-> powered_up) else $error("stopped");
  a_result_code: assert property (
    $changed(conv_result) |-> conv_result == ($past(temp_sense_select) ?
    {$past(temp_code), 2'b00} : sat($past(analog_code)))) else $error("bad result");
  a_ready_lead: assert property (
    $changed(conv_result) && !shot && new_data && $past(new_data) && cs_n && $past(cs_n, 4)
    |-> $past(serial_out_ready)) else $error("no ready lead");
  c_single: cover property ($rose(powered_up) ##[1:300] $rose(new_data));
  c_cont: cover property (!shot && $changed(conv_result));
  c_temp: cover property (temp_sense_select && $changed(conv_result));
endmodule
bind adcsp_top adcsp_asserts u_adcsp_asserts (.core_clk, .rst, .cs_n, .serial_out_ready,
  .serial_out_ready_oe, .analog_code, .temp_code, .temp_sense_select, .fsr_mv, .config_word,
  .conv_result, .new_data, .powered_up);
`default_nettype wire

/* File: testbench/adcsp_host.sv */
// Host SPI master model: 16-bit frames, 48 ns clock only inside frames.
// Assumes the block shifts on rising and samples on falling clock edges.
`timescale 1ns/1ps
`default_nettype none
module adcsp_host (
  output logic sclk, // Serial clock
  output logic cs_n, // Select
  output logic serial_in, // Data out
  input wire logic serial_out_ready // Data in
);
  event done;
  logic [16:0] got;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
  end
  // Extra leading pulses then a long low clock exercise the idle timeout
  task automatic xfer(input logic [15:0] w, input int pre);
    cs_n = 1'b0;
    #500 got[16] = serial_out_ready;
    for (int i = 15 + pre; i >= 0; i--) begin
      #24 sclk = 1'b1;
      serial_in = (i > 15) ? 1'b1 : w[i];
      #24 sclk = 1'b0;
      if (i == 16) #30000;
      if (i < 16) got[i] = serial_out_ready;
    end
    #400 cs_n = 1'b1;
    -> done;
    #400;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for adcsp_top driven by the host SPI model.
// Assumes 18-tick conversions at the fastest rate and a 200-cycle timeout.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED %0t mismatch", $time); end end
module tb_top;
  import adcsp_pkg::*;
  logic core_clk, rst, sclk, cs_n, serial_in, serial_out_ready, serial_out_ready_oe;
  logic out_weak_hold_on, temp_sense_select, new_data, powered_up, fresh, pin_seen;
  logic signed [16:0] analog_code;
  logic [TEMP_BITS-1:0] temp_code;
  logic [2:0] gain_range_select;
  logic [12:0] fsr_mv;
  logic [27:0] lsb_pv;
  logic [15:0] config_word, conv_result, last;
  logic [16:0] expq[$];
  int error_cnt = 0;
  int checks = 0;
  int seed = 80518;
  int fs[8] = '{6144, 4096, 2048, 1024, 512, 256, 256, 256};
  adcsp_top #(.TIMEOUT_CYC(200), .CONV_SHIFT(6)) u_adcsp_top (.core_clk, .rst, .sclk, .cs_n,
    .serial_in, .serial_out_ready, .serial_out_ready_oe, .out_weak_hold_on, .analog_code,
    .temp_code, .gain_range_select, .temp_sense_select, .fsr_mv, .lsb_pv, .config_word,
    .conv_result, .new_data, .powered_up);
  // Released pin reads as the pull-up, or as a flipped level without it
  assign pin_seen = serial_out_ready_oe ? serial_out_ready : (out_weak_hold_on | ~serial_out_ready);
  adcsp_host u_adcsp_host (.sclk, .cs_n, .serial_in, .serial_out_ready(pin_seen));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(u_adcsp_host.done)
    `CHK(u_adcsp_host.got, expq.pop_front())
  function automatic logic [15:0] cw(input logic ss, input logic [2:0] g, input logic md,
    input logic ts, input logic pu);
    return {ss, 3'h0, g, md, 3'h7, ts, pu, 3'h3};
  endfunction
  function automatic logic [15:0] sat(input logic signed [16:0] c);
    return (c > 17'sh07fff) ? 16'h7fff : (c < 17'sh18000) ? 16'h8000 : c[15:0];
  endfunction
  task automatic frame(input logic [15:0] w, input int pre);
    expq.push_back({~fresh, last});
    fresh = 1'b0;
    #10 u_adcsp_host.xfer(w, pre);
  endtask
  task automatic wait_on(input int sel, input logic v);
    for (int n = 0; ((sel == 0) ? new_data : (sel == 1) ? powered_up :
         (conv_result === 16'h1234)) !== v; n++) begin
      @(posedge core_clk);
      #10;
      if (n > 1000) begin
        error_cnt++;
        results();
      end
    end
  endtask
  task automatic results();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    analog_code = '0;
    temp_code = '0;
    last = 16'h0000;
    fresh = 1'b0;
    repeat (6) @(posedge core_clk);
    #10 rst = 1'b0;
    repeat (4) @(posedge core_clk);
    #10 `CHK({config_word, conv_result, new_data, powered_up, serial_out_ready_oe,
      out_weak_hold_on, fsr_mv}, {CFG_RESET, RESULT_RESET, 4'b0001, 13'h0800})
    for (int g = 0; g < 8; g++) begin
      frame(cw(1'b0, 3'(g), 1'b1, 1'b0, g[0]), 0);
      `CHK({gain_range_select, fsr_mv, serial_out_ready_oe, out_weak_hold_on},
        {3'(g), 13'(fs[g]), 1'b0, g[0]})
      `CHK(lsb_pv, 28'(64'(fs[g]) * 1000000000 / 32768))
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      #10 analog_code = (k == 0) ? 17'sh0ffff : (k == 1) ? 17'sh10000 : 17'($random(seed));
      temp_code = 14'($random(seed));
      frame(cw(1'b1, 3'h2, 1'b1, k == 3, 1'b1), 0);
      wait_on(0, 1'b1);
      last = (k == 3) ? {temp_code, 2'b00} : sat(analog_code);
      fresh = 1'b1;
      `CHK({conv_result, temp_sense_select}, {last, k == 3})
      wait_on(1, 1'b0);
      `CHK(config_word[15], 1'b0)
    end
    frame(cw(1'b1, 3'h2, 1'b1, 1'b0, 1'b1), 0);
    frame(cw(1'b1, 3'h2, 1'b1, 1'b0, 1'b1), 0);
    `CHK({config_word[15], powered_up}, 2'b01)
    wait_on(0, 1'b1);
    last = sat(analog_code);
    fresh = 1'b1;
    wait_on(1, 1'b0);
    #2000 `CHK(powered_up, 1'b0)
    frame(cw(1'b0, 3'h1, 1'b1, 1'b0, 1'b1), 5);
    `CHK(config_word, cw(1'b0, 3'h1, 1'b1, 1'b0, 1'b1))
    frame(cw(1'b0, 3'h2, 1'b0, 1'b0, 1'b1), 0);
    repeat (500) begin
      @(posedge core_clk);
      #10 analog_code = 17'($random(seed));
    end
    `CHK(powered_up, 1'b1)
    analog_code = 17'sh01234;
    wait_on(2, 1'b1);
    last = 16'h1234;
    fresh = 1'b1;
    // Frame opens in the lead window and a completion lands mid-frame:
    // pin shows high though unread, and the old word is shifted
    analog_code = 17'sh00def;
    repeat (165) @(posedge core_clk);
    fresh = 1'b0;
    frame(cw(1'b0, 3'h2, 1'b0, 1'b0, 1'b1), 0);
    last = 16'h0def;
    fresh = 1'b1;
    frame(cw(1'b0, 3'h2, 1'b1, 1'b0, 1'b1), 0);
    wait_on(1, 1'b0);
    fresh = 1'b1;
    frame(cw(1'b0, 3'h2, 1'b1, 1'b0, 1'b1), 0);
    frame(cw(1'b0, 3'h2, 1'b0, 1'b0, 1'b1), 0);
    repeat (50) @(posedge core_clk);
    #10 rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #10 rst = 1'b0;
    `CHK({config_word, powered_up}, {CFG_RESET, 1'b0})
    results();
  end
endmodule
`default_nettype wire
